// >>> include/sdcmd_pkg.sv
// sdcmd_pkg: shared constants and types for the sdram command link ends.
// assumes a single 200 MHz clock shared by both ends.
package sdcmd_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int SDCMD_ADDR_W = 12;
    localparam int SDCMD_COL_W = 9;
    localparam int SDCMD_BANKS = 4;
    localparam int SDCMD_DQ_W = 16;
    localparam int SDCMD_PREALL_BIT = 10;
    localparam int SDCMD_MASK_LAT = 2;
    localparam int SDCMD_INIT_REFRESH = 8;
    localparam int SDCMD_MEM_DEPTH = 64;
    localparam int SDCMD_MEM_AW = 6;
    // ------------------------------------------------------------
    // timing, in ns or us with cycle counts derived at 5 ns
    // ------------------------------------------------------------
    localparam int SDCMD_CLK_PS = 5000;
    localparam int SDCMD_T_PAUSE_US = 200;
    localparam int SDCMD_PAUSE_CYC = (SDCMD_T_PAUSE_US * 1000000 + SDCMD_CLK_PS - 1) / SDCMD_CLK_PS;
    localparam int SDCMD_T_RSC_NS = 10;
    localparam int SDCMD_RSC_CYC = (SDCMD_T_RSC_NS * 1000 + SDCMD_CLK_PS - 1) / SDCMD_CLK_PS;
    localparam int SDCMD_T_RCD_NS = 15;
    localparam int SDCMD_RCD_CYC = (SDCMD_T_RCD_NS * 1000 + SDCMD_CLK_PS - 1) / SDCMD_CLK_PS;
    localparam int SDCMD_T_RC_NS = 55;
    localparam int SDCMD_RC_CYC = (SDCMD_T_RC_NS * 1000 + SDCMD_CLK_PS - 1) / SDCMD_CLK_PS;
    localparam int SDCMD_T_RRD_NS = 10;
    localparam int SDCMD_RRD_CYC = (SDCMD_T_RRD_NS * 1000 + SDCMD_CLK_PS - 1) / SDCMD_CLK_PS;
    localparam int SDCMD_T_RP_NS = 15;
    localparam int SDCMD_RP_CYC = (SDCMD_T_RP_NS * 1000 + SDCMD_CLK_PS - 1) / SDCMD_CLK_PS;
    localparam int SDCMD_T_RFC_NS = 55;
    localparam int SDCMD_RFC_CYC = (SDCMD_T_RFC_NS * 1000 + SDCMD_CLK_PS - 1) / SDCMD_CLK_PS;
    localparam int SDCMD_T_RASMAX_US = 100;
    localparam int SDCMD_RASMAX_CYC = (SDCMD_T_RASMAX_US * 1000000) / SDCMD_CLK_PS;
    localparam logic [11:0] SDCMD_MODE_DEFAULT = 12'h030;
    // ------------------------------------------------------------
    // command encoding {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SDCMD_CMD_MRS = 4'h0,
        SDCMD_CMD_REF = 4'h1,
        SDCMD_CMD_PRE = 4'h2,
        SDCMD_CMD_ACT = 4'h3,
        SDCMD_CMD_WR = 4'h4,
        SDCMD_CMD_RD = 4'h5,
        SDCMD_CMD_BST = 4'h6,
        SDCMD_CMD_NOP = 4'h7,
        SDCMD_CMD_DESEL = 4'h8
    } sdcmd_cmd_t;
endpackage : sdcmd_pkg

// >>> include/sdcmd_if.sv
// sdcmd_if: pins between the memory controller and the sdram device.
// dq is resolved here from the two enables, controller first.
`timescale 1ns/1ps
`default_nettype none
interface sdcmd_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_select_low;
    logic bank_select_high;
    logic [11:0] addr;
    logic lower_byte_mask;
    logic upper_byte_mask;
    logic [15:0] dq_ctl;
    logic dq_ctl_oe;
    logic [15:0] dq_dev;
    logic [1:0] dq_dev_oe;
    logic [15:0] dq;
    // bus level: whoever drives wins, per byte for the device
    assign dq = dq_ctl_oe ? dq_ctl : {dq_dev_oe[1] ? dq_dev[15:8] : 8'h00,
                                     dq_dev_oe[0] ? dq_dev[7:0] : 8'h00};
    modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, addr,
                 lower_byte_mask, upper_byte_mask, dq_ctl, dq_ctl_oe, input dq);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, addr,
                 lower_byte_mask, upper_byte_mask, dq, output dq_dev, dq_dev_oe);
endinterface : sdcmd_if
`default_nettype wire

// >>> logic/sdcmd_device.sv
// sdcmd_device: command decoder, bank tracker and small data store of the sdram.
// assumes the controller keeps all timing spacing; only a few words are stored.
// Overview of operation
// RULE1: row on addr 0-11, column 0-8
// RULE2: bank selects pick bank for row/column
// RULE3: chip select high ignores new commands
// RULE4: ras cas we sampled decode the command
// RULE5: read mask floats outputs two cycles later; here the outputs float two cycles after the mask is sampled, in step with read data
// RULE6: write mask blocks byte same cycle
// RULE7: separate lower and upper byte masks
// RULE8: cke low enters power-down, suspend, self-refresh
// RULE9: mode register undefined until programmed
// RULE10: nop during ramp, wait 200 us, precharge all
// RULE11: masks and cke high during pause
// RULE12: mode set plus eight refreshes after precharge
// RULE13: mode set needs banks idle, cke high
// RULE14: all low is mode set, addr loaded
// RULE15: wait trsc after mode set
// RULE16: activate first, then wait trcd
// RULE17: precharge before reactivate, space by trc
// RULE18: activates to different banks spaced trrd
// RULE19: no bank open beyond tras max
// RULE20: ras high cas low, we selects read/write
// RULE21: new row needs precharge then activate
// RULE22: column commands accepted every cycle
// RULE23: addr 10 selects single or all precharge
// RULE24: track open state and row per bank
`timescale 1ns/1ps
`default_nettype none
module sdcmd_device
    import sdcmd_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    sdcmd_if.dev link,
    output logic mode_valid_out,
    output logic [11:0] mode_out,
    output logic [3:0] bank_open_out,
    output logic powered_down_out,
    output logic self_refresh_out
);
    typedef enum logic [2:0] {
        SDCMD_DV_RUN = 3'b001,
        SDCMD_DV_PDN = 3'b010,
        SDCMD_DV_SREF = 3'b100
    } sdcmd_dv_state_t;

    typedef struct packed {
        sdcmd_dv_state_t st;
        logic mode_valid;
        logic [11:0] mode;
        logic [3:0] open;
        logic [3:0][11:0] row;
        logic [1:0][1:0] rd_pipe; // read data valid, per latency stage
        logic [1:0][1:0] mask_pipe; // byte masks delayed for reads
        logic [1:0][15:0] data_pipe;
        logic [15:0] dq_out;
        logic [1:0] dq_oe;
    } sdcmd_dv_t;

    sdcmd_dv_t cur;
    sdcmd_dv_t next_cur;
    logic [15:0] mem [SDCMD_MEM_DEPTH];
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [1:0] dqm;
    logic mem_we;
    logic [SDCMD_MEM_AW-1:0] mem_wa;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n}; // RULE4
    assign bank = {link.bank_select_high, link.bank_select_low}; // RULE2
    assign dqm = {link.upper_byte_mask, link.lower_byte_mask}; // RULE7
    // store address folds bank, row and column bits into a small array
    assign mem_wa = SDCMD_MEM_AW'({bank, cur.row[bank][1:0], link.addr[1:0]}); // RULE1

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        mem_we = 1'b0;
        // read pipeline shifts every cycle, masks ride in step with it over two stages
        next_cur.rd_pipe[1] = cur.rd_pipe[0];
        next_cur.rd_pipe[0] = 2'b00;
        next_cur.mask_pipe[1] = cur.mask_pipe[0];
        next_cur.mask_pipe[0] = dqm;
        next_cur.data_pipe[1] = cur.data_pipe[0];
        next_cur.data_pipe[0] = mem[mem_wa];
        next_cur.dq_out = cur.data_pipe[1];
        next_cur.dq_oe = cur.rd_pipe[1] & ~cur.mask_pipe[1]; // RULE5
        case (cur.st)
            SDCMD_DV_RUN: begin
                if (!link.cke) begin
                    // cke low: self refresh with refresh command, else power down/suspend
                    next_cur.st = (cmd == SDCMD_CMD_REF) ? SDCMD_DV_SREF : SDCMD_DV_PDN; // RULE8
                end
                if (link.cke && !link.cs_n) begin // RULE3
                    case (cmd)
                        SDCMD_CMD_MRS: begin
                            next_cur.mode = link.addr; // RULE14
                            next_cur.mode_valid = 1'b1; // RULE9
                        end
                        SDCMD_CMD_ACT: begin
                            next_cur.open[bank] = 1'b1; // RULE24
                            next_cur.row[bank] = link.addr; // RULE1
                        end
                        SDCMD_CMD_PRE: begin
                            if (link.addr[SDCMD_PREALL_BIT]) begin // RULE23
                                next_cur.open = 4'h0;
                            end else begin
                                next_cur.open[bank] = 1'b0; // RULE24
                            end
                        end
                        SDCMD_CMD_RD: begin
                            // every cycle is legal; each read takes its own pipeline slot
                            next_cur.rd_pipe[0] = 2'b11; // RULE20 RULE22
                        end
                        SDCMD_CMD_WR: begin
                            mem_we = cur.open[bank]; // RULE20 RULE22
                        end
                        default: begin
                        end
                    endcase
                end
            end
            SDCMD_DV_PDN, SDCMD_DV_SREF: begin
                if (link.cke) begin
                    next_cur.st = SDCMD_DV_RUN; // RULE8
                end
            end
            default: begin
                next_cur.st = SDCMD_DV_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers; the store has no reset, contents are undefined anyway
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cur <= '0;
            cur.st <= SDCMD_DV_RUN;
            cur.mode <= SDCMD_MODE_DEFAULT;
        end else begin
            cur <= next_cur;
        end
    end

    // write mask acts in the command cycle itself
    always_ff @(posedge sys_clk_in) begin
        if (mem_we && !dqm[0]) begin
            mem[mem_wa][7:0] <= link.dq[7:0]; // RULE6
        end
        if (mem_we && !dqm[1]) begin
            mem[mem_wa][15:8] <= link.dq[15:8]; // RULE6
        end
    end

    assign link.dq_dev = cur.dq_out;
    assign link.dq_dev_oe = cur.dq_oe;
    assign mode_valid_out = cur.mode_valid;
    assign mode_out = cur.mode;
    assign bank_open_out = cur.open;
    assign powered_down_out = (cur.st == SDCMD_DV_PDN);
    assign self_refresh_out = (cur.st == SDCMD_DV_SREF);
endmodule : sdcmd_device
`default_nettype wire

// >>> logic/sdcmd_ctl.sv
// sdcmd_ctl: controller end; runs power-up init, then one-word accesses.
// assumes the user holds req until ack; one access in flight at a time.
`timescale 1ns/1ps
`default_nettype none
module sdcmd_ctl
    import sdcmd_pkg::*;
#(
    parameter int PAUSE_CYC = SDCMD_PAUSE_CYC,
    parameter int RASMAX_CYC = SDCMD_RASMAX_CYC
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    sdcmd_if.ctl link,
    input wire logic req_in,
    input wire logic req_write_in,
    input wire logic [1:0] req_bank_in,
    input wire logic [11:0] req_row_in,
    input wire logic [8:0] req_col_in,
    input wire logic [15:0] req_wdata_in,
    input wire logic [1:0] req_mask_in,
    output logic ack_out,
    output logic [15:0] rdata_out,
    output logic init_done_out
);
    typedef enum logic [6:0] {
        SDCMD_CS_PAUSE = 7'h01,
        SDCMD_CS_PREALL = 7'h02,
        SDCMD_CS_REF = 7'h04,
        SDCMD_CS_MRS = 7'h08,
        SDCMD_CS_IDLE = 7'h10,
        SDCMD_CS_COL = 7'h20,
        SDCMD_CS_RDWAIT = 7'h40
    } sdcmd_cs_t;

    typedef struct packed {
        sdcmd_cs_t st;
        logic [31:0] wait_cnt; // cycles until next command allowed
        logic [31:0] open_cnt; // cycles the open bank has stood active
        logic [3:0] ref_cnt;
        logic [3:0] cmd;
        logic [1:0] bank;
        logic [11:0] addr;
        logic [1:0] dqm;
        logic [15:0] wdata;
        logic wdrive;
        logic [3:0] open;
        logic [3:0][11:0] row;
        logic [2:0] rd_wait;
        logic ack;
        logic [15:0] rdata;
        logic done;
    } sdcmd_ct_t;

    sdcmd_ct_t cur;
    sdcmd_ct_t next_cur;
    logic hit;

    assign hit = cur.open[req_bank_in] && (cur.row[req_bank_in] == req_row_in);

    // ------------------------------------------------------------
    // sequencer; only one bank is used at a time, trading bandwidth for
    // simplicity so trrd holds trivially
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.cmd = SDCMD_CMD_NOP;
        next_cur.wdrive = 1'b0;
        next_cur.dqm = 2'b00;
        next_cur.ack = 1'b0;
        next_cur.open_cnt = (cur.open != 4'h0) ? cur.open_cnt + 32'd1 : 32'd0;
        if (cur.wait_cnt != 32'd0) begin
            next_cur.wait_cnt = cur.wait_cnt - 32'd1;
        end
        case (cur.st)
            SDCMD_CS_PAUSE: begin
                next_cur.dqm = 2'b11; // RULE11
                if (cur.wait_cnt == 32'd0) begin // RULE10
                    next_cur.st = SDCMD_CS_PREALL;
                end
            end
            SDCMD_CS_PREALL: begin
                next_cur.cmd = SDCMD_CMD_PRE;
                next_cur.addr = 12'h400; // RULE23
                next_cur.wait_cnt = 32'(SDCMD_RP_CYC);
                next_cur.st = SDCMD_CS_REF;
                next_cur.open = 4'h0;
            end
            SDCMD_CS_REF: begin
                if (cur.wait_cnt == 32'd0) begin
                    if (cur.ref_cnt == 4'(SDCMD_INIT_REFRESH)) begin // RULE12
                        next_cur.st = SDCMD_CS_MRS;
                    end else begin
                        next_cur.cmd = SDCMD_CMD_REF;
                        next_cur.ref_cnt = cur.ref_cnt + 4'h1;
                        next_cur.wait_cnt = 32'(SDCMD_RFC_CYC);
                    end
                end
            end
            SDCMD_CS_MRS: begin
                // banks idle and cke high long before this point; mode unknown till now
                next_cur.cmd = SDCMD_CMD_MRS; // RULE13 RULE14 RULE9
                next_cur.addr = SDCMD_MODE_DEFAULT;
                next_cur.wait_cnt = 32'(SDCMD_RSC_CYC); // RULE15
                next_cur.st = SDCMD_CS_IDLE;
            end
            SDCMD_CS_IDLE: begin
                next_cur.done = 1'b1;
                if (cur.wait_cnt == 32'd0) begin
                    if (cur.open != 4'h0 && (!req_in || !hit || cur.open_cnt >= 32'(RASMAX_CYC - 8))) begin
                        // close the bank: no request, row change or tras max near
                        next_cur.cmd = SDCMD_CMD_PRE; // RULE19 RULE21
                        next_cur.addr = 12'h400;
                        next_cur.open = 4'h0;
                        next_cur.wait_cnt = 32'(SDCMD_RP_CYC);
                    end else if (req_in && cur.open == 4'h0) begin
                        next_cur.cmd = SDCMD_CMD_ACT; // RULE16 RULE17
                        next_cur.bank = req_bank_in;
                        next_cur.addr = req_row_in; // RULE1
                        next_cur.open[req_bank_in] = 1'b1;
                        next_cur.row[req_bank_in] = req_row_in;
                        next_cur.wait_cnt = 32'(SDCMD_RCD_CYC); // RULE16
                    end else if (req_in && hit) begin
                        next_cur.st = SDCMD_CS_COL;
                    end
                end
            end
            SDCMD_CS_COL: begin
                next_cur.cmd = req_write_in ? SDCMD_CMD_WR : SDCMD_CMD_RD; // RULE20
                next_cur.bank = req_bank_in; // RULE2
                next_cur.addr = {3'h0, req_col_in}; // RULE1
                next_cur.dqm = req_mask_in;
                next_cur.wdata = req_wdata_in;
                next_cur.wdrive = req_write_in;
                next_cur.rd_wait = 3'd4;
                // trc covers the next activate after the precharge + rp
                next_cur.wait_cnt = 32'(SDCMD_RC_CYC); // RULE17
                next_cur.st = req_write_in ? SDCMD_CS_IDLE : SDCMD_CS_RDWAIT;
                next_cur.ack = req_write_in;
            end
            SDCMD_CS_RDWAIT: begin
                next_cur.rd_wait = cur.rd_wait - 3'd1;
                if (cur.rd_wait == 3'd1) begin
                    next_cur.rdata = link.dq;
                    next_cur.ack = 1'b1;
                    next_cur.st = SDCMD_CS_IDLE;
                end
            end
            default: begin
                next_cur.st = SDCMD_CS_PAUSE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cur <= '0;
            cur.st <= SDCMD_CS_PAUSE;
            cur.cmd <= SDCMD_CMD_NOP; // RULE10
            cur.dqm <= 2'b11;
            cur.wait_cnt <= 32'(PAUSE_CYC);
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign link.cke = 1'b1; // RULE11
    assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cur.cmd;
    assign {link.bank_select_high, link.bank_select_low} = cur.bank;
    assign link.addr = cur.addr;
    assign {link.upper_byte_mask, link.lower_byte_mask} = cur.dqm;
    assign link.dq_ctl = cur.wdata;
    assign link.dq_ctl_oe = cur.wdrive;
    assign ack_out = cur.ack;
    assign rdata_out = cur.rdata;
    assign init_done_out = cur.done;
endmodule : sdcmd_ctl
`default_nettype wire

// >>> testbench/sdcmd_sva.sv
// sdcmd_sva: timing and framing checks on the pins between controller and device.
// assumes the bench feeds it the link interface signals by name, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sdcmd_sva
    import sdcmd_pkg::*;
#(
    parameter int PAUSE_CYC = SDCMD_PAUSE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [11:0] addr,
    input wire logic lower_byte_mask,
    input wire logic upper_byte_mask,
    input wire logic dq_ctl_oe,
    input wire logic [1:0] dq_dev_oe
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    logic [3:0] cmd;
    logic idle_cmd;
    logic col_cmd;
    logic [15:0] since_rst;
    logic started;
    logic mrs_seen;
    logic [3:0] ref_cnt;
    // deselect counts as idle whatever the strobes show
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign idle_cmd = cs_n || (cmd == SDCMD_CMD_NOP);
    assign col_cmd = (cmd == SDCMD_CMD_RD) || (cmd == SDCMD_CMD_WR);
    // saturating age since reset, first command flag, refreshes before mode set
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            since_rst <= 16'h0000;
            started <= 1'b0;
            mrs_seen <= 1'b0;
            ref_cnt <= 4'h0;
        end else begin
            if (since_rst != 16'hffff) since_rst <= since_rst + 16'h0001;
            if (!idle_cmd) started <= 1'b1;
            if (cmd == SDCMD_CMD_MRS) mrs_seen <= 1'b1;
            if (cmd == SDCMD_CMD_REF && !mrs_seen) ref_cnt <= ref_cnt + 4'h1;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_act;
        cmd == SDCMD_CMD_ACT;
    endsequence
    sequence s_mrs;
        cmd == SDCMD_CMD_MRS;
    endsequence
    sequence s_rd;
        cmd == SDCMD_CMD_RD;
    endsequence
    pause_idle_a: assert property (since_rst < PAUSE_CYC |->
        idle_cmd && cke && lower_byte_mask && upper_byte_mask) else $error("pins busy in pause");
    first_cmd_a: assert property (!started && !idle_cmd |->
        cmd == SDCMD_CMD_PRE && addr[SDCMD_PREALL_BIT] && since_rst >= PAUSE_CYC)
        else $error("first command not a late precharge all");
    init_refresh_a: assert property (s_mrs ##0 !mrs_seen |-> ref_cnt == 4'h8)
        else $error("wrong refresh count before mode set");
    mrs_cke_a: assert property (s_mrs |-> cke && $past(cke))
        else $error("mode set without clock enable");
    mrs_gap_a: assert property (s_mrs |=> idle_cmd)
        else $error("command too soon after mode set");
    act_to_col_a: assert property (s_act |=> !col_cmd ##1 !col_cmd)
        else $error("column command too soon after activate");
    act_space_a: assert property (s_act |=> cmd != SDCMD_CMD_ACT)
        else $error("activates too close");
    wr_drive_a: assert property (dq_ctl_oe |-> cmd == SDCMD_CMD_WR)
        else $error("controller drives data outside write");
    no_contend_a: assert property (!(dq_ctl_oe && dq_dev_oe != 2'b00))
        else $error("both ends drive data");
    low_float_a: assert property (s_rd ##0 lower_byte_mask |-> ##3 !dq_dev_oe[0])
        else $error("lower byte driven while masked");
    up_float_a: assert property (s_rd ##0 upper_byte_mask |-> ##3 !dq_dev_oe[1])
        else $error("upper byte driven while masked");
endmodule : sdcmd_sva
`default_nettype wire

// >>> testbench/tb_sdram_command_init_bank_control.sv
// tb_sdram_command_init_bank_control: controller and device joined back to back.
// assumes shortened pause and open-time parameters; a word model checks read data.
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_command_init_bank_control;
    import sdcmd_pkg::*;
    localparam int PAUSE_SIM = 20;
    localparam int RASMAX_SIM = 30;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic req_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [1:0] req_bank_in = 2'h0;
    logic [11:0] req_row_in = 12'h000;
    logic [8:0] req_col_in = 9'h000;
    logic [15:0] req_wdata_in = 16'h0000;
    logic [1:0] req_mask_in = 2'h0;
    logic ack_out;
    logic [15:0] rdata_out;
    logic init_done_out;
    logic mode_valid_out;
    logic [11:0] mode_out;
    logic [3:0] bank_open_out;
    logic powered_down_out;
    logic self_refresh_out;
    int errors = 0;
    int samples_checked = 0;
    logic [31:0] rng = 32'h00000058;
    int model_mem [int];
    sdcmd_if link ();
    sdcmd_ctl #(.PAUSE_CYC(PAUSE_SIM), .RASMAX_CYC(RASMAX_SIM)) sdcmd_ctl_i (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .link(link), .req_in(req_in),
        .req_write_in(req_write_in), .req_bank_in(req_bank_in), .req_row_in(req_row_in),
        .req_col_in(req_col_in), .req_wdata_in(req_wdata_in), .req_mask_in(req_mask_in),
        .ack_out(ack_out), .rdata_out(rdata_out), .init_done_out(init_done_out));
    sdcmd_device sdcmd_device_i (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .link(link),
        .mode_valid_out(mode_valid_out), .mode_out(mode_out), .bank_open_out(bank_open_out),
        .powered_down_out(powered_down_out), .self_refresh_out(self_refresh_out));
    sdcmd_sva #(.PAUSE_CYC(PAUSE_SIM)) sdcmd_sva_i (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .cke(link.cke), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr),
        .lower_byte_mask(link.lower_byte_mask), .upper_byte_mask(link.upper_byte_mask),
        .dq_ctl_oe(link.dq_ctl_oe), .dq_dev_oe(link.dq_dev_oe));
    // free-running 200 MHz clock
    always #2.5 sys_clk_in = ~sys_clk_in;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xorshift
    task automatic give_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    // one access, held until ack; the wire is watched for row and column framing
    task automatic access(input logic wr, input logic [1:0] bank, input logic [11:0] row,
                          input logic [8:0] col, input logic [15:0] wd, input logic [1:0] mask,
                          output logic [15:0] rd);
        int n;
        logic [3:0] cmd;
        logic got;
        got = 1'b0;
        @(posedge sys_clk_in);
        #1;
        req_in = 1'b1;
        req_write_in = wr;
        req_bank_in = bank;
        req_row_in = row;
        req_col_in = col;
        req_wdata_in = wd;
        req_mask_in = mask;
        for (n = 0; n < 400 && !got; n++) begin
            @(posedge sys_clk_in);
            #1;
            cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
            if (cmd == SDCMD_CMD_ACT) begin
                check(16'({link.bank_select_high, link.bank_select_low}), 16'(bank), "act bank");
                check(16'(link.addr), 16'(row), "row address");
            end
            if (cmd == SDCMD_CMD_RD || cmd == SDCMD_CMD_WR) begin
                check(16'(cmd), wr ? 16'(SDCMD_CMD_WR) : 16'(SDCMD_CMD_RD), "column cmd");
                check(16'({link.bank_select_high, link.bank_select_low}), 16'(bank), "col bank");
                check(16'(link.addr[8:0]), 16'(col), "column address");
            end
            if (ack_out === 1'b1) got = 1'b1;
        end
        if (!got) begin
            errors++;
            $display("[FAIL] %0t access never acknowledged", $time);
            give_verdict();
        end
        rd = rdata_out;
        req_in = 1'b0;
    endtask : access
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int i;
        int key;
        int exp;
        logic [1:0] bank;
        logic [11:0] row;
        logic [8:0] col;
        logic [15:0] w0;
        logic [15:0] w1;
        logic [1:0] wm;
        logic [1:0] rm;
        logic [15:0] rd;
        repeat (10) @(posedge sys_clk_in);
        #1;
        nrst_in = 1'b1;
        check(16'(mode_valid_out), 16'h0000, "mode valid early");
        for (i = 0; i < 3000 && init_done_out !== 1'b1; i++) @(posedge sys_clk_in);
        #1;
        check(16'(init_done_out), 16'h0001, "init done");
        check(16'(mode_out), 16'(SDCMD_MODE_DEFAULT), "mode value");
        check(16'(mode_valid_out), 16'h0001, "mode valid");
        check(16'(bank_open_out), 16'h0000, "banks closed");
        $display("test init done");
        // fill, masked overwrite, masked read of one word per pass; random rows force misses
        for (i = 0; i < 12; i++) begin
            rng = xorshift(rng);
            bank = rng[1:0];
            row = rng[13:2];
            col = rng[22:14];
            rng = xorshift(rng);
            w0 = rng[15:0];
            w1 = rng[31:16];
            rng = xorshift(rng);
            wm = rng[1:0];
            rm = (i == 0) ? 2'b11 : rng[3:2];
            key = int'({bank, row, col});
            access(1'b1, bank, row, col, w0, 2'b00, rd);
            model_mem[key] = int'(w0);
            access(1'b1, bank, row, col, w1, wm, rd);
            exp = model_mem[key];
            if (!wm[0]) exp = (exp & 32'h0000ff00) | int'(w1 & 16'h00ff);
            if (!wm[1]) exp = (exp & 32'h000000ff) | int'(w1 & 16'hff00);
            model_mem[key] = exp;
            access(1'b0, bank, row, col, 16'h0000, rm, rd);
            if (rm[0]) exp = exp & 32'h0000ff00;
            if (rm[1]) exp = exp & 32'h000000ff;
            check(rd, exp[15:0], "read data");
            check(16'(bank_open_out[bank]), 16'h0001, "bank open");
            check(16'({powered_down_out, self_refresh_out}), 16'h0000, "low power");
        end
        $display("test access done");
        give_verdict();
    end
endmodule : tb_sdram_command_init_bank_control
`default_nettype wire
